// >>> design/gpio_port_bit_rmw.sv
// Eight-pin general purpose port with APB registers and a bit read-modify-write sequencer.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module gpio_port_bit_rmw (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [31:0] rdata;
    } port_t;

    port_t st_ff;
    port_t nxt_st;
    rmw_if rmw ();

    logic access;
    logic done;
    logic hit_data;
    logic hit_dir;
    logic hit_cmd;
    logic hit_status;
    logic mapped;
    logic [7:0] cur_view;
    logic wr_ok;

    // Bus accesses wait while the sequencer owns the port, so its write-back never meets a bus write.
    assign access = psel && penable;
    assign pready = access && !rmw.busy;
    assign done = pready;
    assign hit_data = paddr == gpio_port_pkg::OFF_DATA;
    assign hit_dir = paddr == gpio_port_pkg::OFF_DIR;
    assign hit_cmd = paddr == gpio_port_pkg::OFF_CMD;
    assign hit_status = paddr == gpio_port_pkg::OFF_STATUS;
    assign mapped = hit_data || hit_dir || hit_cmd || hit_status;
    assign pslverr = done && !mapped;
    assign wr_ok = done && pwrite && pstrb[0];

    // Per pin read view: an output shows its latch bit, an input shows the pin level.
    for (genvar n = 0; n < 8; n++) begin : g_view
        assign cur_view[n] = st_ff.dir[n] ? st_ff.latch[n] : pin_in[n];
    end

    assign rmw.data_view = cur_view;
    // The sequencer reads through the shared view on purpose, so input-pin latch bits take the pin levels.
    assign rmw.start = wr_ok && hit_cmd;
    assign rmw.set_bit = pwdata[gpio_port_pkg::CMD_SET_BIT];
    assign rmw.bit_idx = pwdata[gpio_port_pkg::CMD_IDX_LSB +: 3];
    assign rmw.to_dir = pwdata[gpio_port_pkg::CMD_DIR_BIT];

    always_comb begin
        nxt_st = st_ff;
        if (wr_ok) begin
            if (hit_data) begin
                nxt_st.latch = pwdata[7:0];
            end
            if (hit_dir) begin
                nxt_st.dir = pwdata[7:0];
            end
        end
        if (rmw.wr_en) begin
            if (rmw.wr_to_dir) begin
                nxt_st.dir = rmw.wr_byte;
            end else begin
                nxt_st.latch = rmw.wr_byte;
            end
        end
        // The view is taken from the values after this edge, so a read never returns a stale latch.
        // A status read that waited on the sequencer may still show busy, since the word is taken an edge early.
        if (psel && !pwrite) begin
            if (hit_data) begin
                nxt_st.rdata = {24'h000000, (nxt_st.dir & nxt_st.latch) | (~nxt_st.dir & pin_in)};
            end else if (hit_dir) begin
                nxt_st.rdata = {24'h000000, gpio_port_pkg::DIR_READ_VALUE};
            end else if (hit_status) begin
                nxt_st.rdata = {31'h00000000, rmw.busy};
            end else begin
                nxt_st.rdata = gpio_port_pkg::RDATA_RESET;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff.latch <= gpio_port_pkg::LATCH_RESET;
            st_ff.dir <= gpio_port_pkg::DIR_RESET;
            st_ff.rdata <= gpio_port_pkg::RDATA_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    bit_rmw_engine u_engine (
        .pclk(pclk),
        .presetn(presetn),
        .rmw(rmw.engine)
    );

    assign prdata = st_ff.rdata;
    assign pin_out = st_ff.latch;
    assign pin_oe = st_ff.dir;

    data_read_view_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !pwrite && hit_data) |=>
        (prdata[7:0] == ((st_ff.dir & st_ff.latch) | (~st_ff.dir & $past(pin_in)))))
        else $error("Data read does not mix pin levels and latch by direction.");

    latch_read_view_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !pwrite && hit_data) |=>
        ((prdata[7:0] & st_ff.dir) == (st_ff.latch & st_ff.dir)) && (prdata[31:8] == 24'h000000))
        else $error("Output pin bits did not read back the latch.");

    dir_reads_ones_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && !pwrite && hit_dir) |-> (prdata == 32'h0000_00ff))
        else $error("Direction register read did not return all ones.");

    latch_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && pwrite && hit_data && pstrb[0]) |=> (st_ff.latch == $past(pwdata[7:0])))
        else $error("Data write did not store all eight latch bits.");

    pin_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && pwrite && hit_data && pstrb[0]) |=> ((pin_out & pin_oe) == ($past(pwdata[7:0]) & pin_oe)))
        else $error("Output pins did not follow the written latch.");

    dir_drives_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && pwrite && hit_dir && pstrb[0]) |=> (pin_oe == $past(pwdata[7:0])))
        else $error("Direction write did not set pin drivers.");

    rmw_data_writeback_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rmw.wr_en && !rmw.wr_to_dir) |=> (st_ff.latch == $past(rmw.wr_byte)) && $stable(st_ff.dir))
        else $error("Sequencer write-back did not land in the latch alone.");

    shared_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && pwrite && hit_data && pstrb[0]) |=> $stable(st_ff.dir))
        else $error("Data address write touched the direction register.");

    stall_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        rmw.busy |-> !pready)
        else $error("Bus access completed while the sequencer was busy.");

    dir_keeps_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ok && hit_dir) |=>
        $stable(st_ff.latch))
        else $error("Direction write changed the output latch.");

    strobe_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && pwrite && !pstrb[0]) |=>
        ($stable(st_ff.latch) && $stable(st_ff.dir)))
        else $error("Write without byte strobe changed a register.");

    rmw_dir_writeback_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rmw.wr_en && rmw.wr_to_dir) |=>
        ((st_ff.dir == $past(rmw.wr_byte)) && $stable(st_ff.latch)))
        else $error("Sequencer write-back did not land in the direction register alone.");

    cmd_defers_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && pwrite && hit_cmd) |=>
        ($stable(st_ff.latch) && $stable(st_ff.dir)))
        else $error("Command write changed a register before the read step.");

    input_bits_live_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !pwrite && hit_data) |=>
        (((prdata[7:0] ^ $past(pin_in)) & ~st_ff.dir) == 8'h00))
        else $error("Input pin bits did not read back the pin level.");

    upper_bits_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !pwrite) |=>
        (prdata[31:8] == 24'h000000))
        else $error("Read data carried bits above the eight port bits.");

    unmapped_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (done && pwrite && !mapped) |=>
        ($stable(st_ff.latch) && $stable(st_ff.dir)))
        else $error("Write to an unmapped address changed a register.");

    dir_setup_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !pwrite && hit_dir) |=>
        (prdata == {24'h000000, gpio_port_pkg::DIR_READ_VALUE}))
        else $error("Direction read word was not all ones.");

    status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !pwrite && hit_status) |=>
        (prdata == {31'h0, $past(rmw.busy)}))
        else $error("Status read did not return the sequencer busy bit.");

    cmd_reads_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !pwrite && hit_cmd) |=>
        (prdata == 32'h0000_0000))
        else $error("Command address did not read as zero.");

    unmapped_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !pwrite && !mapped) |=>
        (prdata == gpio_port_pkg::RDATA_RESET))
        else $error("Unmapped read did not return zero.");

    cover_read_mixed: cover property (@(posedge pclk) disable iff (!presetn)
        done && !pwrite && hit_data && (st_ff.dir != 8'h00) && (st_ff.dir != 8'hff));
    cover_dir_read: cover property (@(posedge pclk) disable iff (!presetn)
        done && !pwrite && hit_dir);
    cover_stalled_access: cover property (@(posedge pclk) disable iff (!presetn)
        access && rmw.busy);
endmodule : gpio_port_bit_rmw
`default_nettype wire

// >>> inc/gpio_port_pkg.sv
// Shared constants and types for the eight-pin port with bit read-modify-write support.
package gpio_port_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFF_DATA = 12'h000;
    localparam logic [11:0] OFF_DIR = 12'h004;
    localparam logic [11:0] OFF_CMD = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] DIR_READ_VALUE = 8'hff;
    localparam int unsigned CMD_IDX_LSB = 0;
    localparam int unsigned CMD_SET_BIT = 3;
    localparam int unsigned CMD_DIR_BIT = 4;
    localparam int unsigned STATUS_BUSY_BIT = 0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        RMW_IDLE,
        RMW_READ,
        RMW_WRITE
    } rmw_state_t;
endpackage : gpio_port_pkg

// >>> inc/rmw_if.sv
// Carrier between the port core and its bit read-modify-write sequencer.
`timescale 1ns/10ps
`default_nettype none
interface rmw_if;
    logic start;
    logic set_bit;
    logic [2:0] bit_idx;
    logic to_dir;
    logic [7:0] data_view;
    logic busy;
    logic wr_en;
    logic wr_to_dir;
    logic [7:0] wr_byte;

    modport core (
        output start,
        output set_bit,
        output bit_idx,
        output to_dir,
        output data_view,
        input busy,
        input wr_en,
        input wr_to_dir,
        input wr_byte
    );
    modport engine (
        input start,
        input set_bit,
        input bit_idx,
        input to_dir,
        input data_view,
        output busy,
        output wr_en,
        output wr_to_dir,
        output wr_byte
    );
endinterface : rmw_if
`default_nettype wire

// >>> design/bit_rmw_engine.sv
// Sequencer that reads a port byte, changes one bit and writes the byte back.
`timescale 1ns/10ps
`default_nettype none
module bit_rmw_engine (
    input wire logic pclk,
    input wire logic presetn,
    rmw_if.engine rmw
);
    typedef struct packed {
        gpio_port_pkg::rmw_state_t state;
        logic set_bit;
        logic [2:0] idx;
        logic to_dir;
        logic [7:0] byte_val;
    } eng_t;

    eng_t st_ff;
    eng_t nxt_st;
    logic [7:0] read_byte;

    // The direction register cannot be read back, so its read view is all ones, as software would see.
    assign read_byte = st_ff.to_dir ? gpio_port_pkg::DIR_READ_VALUE : rmw.data_view;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff.state)
            gpio_port_pkg::RMW_IDLE: begin
                if (rmw.start) begin
                    nxt_st.state = gpio_port_pkg::RMW_READ;
                    nxt_st.set_bit = rmw.set_bit;
                    nxt_st.idx = rmw.bit_idx;
                    nxt_st.to_dir = rmw.to_dir;
                end
            end
            gpio_port_pkg::RMW_READ: begin
                nxt_st.byte_val = read_byte;
                nxt_st.byte_val[st_ff.idx] = st_ff.set_bit;
                nxt_st.state = gpio_port_pkg::RMW_WRITE;
            end
            gpio_port_pkg::RMW_WRITE: begin
                nxt_st.state = gpio_port_pkg::RMW_IDLE;
            end
            default: begin
                nxt_st.state = gpio_port_pkg::RMW_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rmw.busy = st_ff.state != gpio_port_pkg::RMW_IDLE;
    assign rmw.wr_en = st_ff.state == gpio_port_pkg::RMW_WRITE;
    assign rmw.wr_to_dir = st_ff.to_dir;
    assign rmw.wr_byte = st_ff.byte_val;

    rmw_one_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_ff.state == gpio_port_pkg::RMW_READ) |=>
        (((rmw.wr_byte ^ $past(read_byte)) & ~(8'h01 << st_ff.idx)) == 8'h00)
        && (rmw.wr_byte[st_ff.idx] == st_ff.set_bit))
        else $error("Sequencer changed a bit other than the addressed one.");

    rmw_latency_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rmw.start && !rmw.busy) |-> ##2 rmw.wr_en ##1 !rmw.busy)
        else $error("Read-modify-write did not write back two cycles after start.");

    cover_set_data: cover property (@(posedge pclk) disable iff (!presetn)
        rmw.start && !rmw.busy && rmw.set_bit && !rmw.to_dir);
    cover_clr_dir: cover property (@(posedge pclk) disable iff (!presetn)
        rmw.start && !rmw.busy && !rmw.set_bit && rmw.to_dir);
endmodule : bit_rmw_engine
`default_nettype wire

// >>> tb/pin_model.sv
// Far side of the port: external drivers that meet the port's own drivers on the wires.
`timescale 1ns/10ps
`default_nettype none
module pin_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    // An external driver only wins on a wire whose port driver is released.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
        end
    end
endmodule : pin_model
`default_nettype wire

// >>> tb/tb.sv
// Bench for the eight-pin port: bus tasks, pin scenarios and the closing report.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end \
end
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] pin_in, pin_out, pin_oe, ext_level;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;
    gpio_port_bit_rmw i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    pin_model i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    // A hung handshake would stall the main sequence, so the cycle ceiling ends the run.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        // Answer is taken at the edge that samples pready high, then the request is released.
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        ext_level = 8'h00;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, gpio_port_pkg::OFF_DATA, 32'h0, 4'hf);
        `CHK("data read", 32'h0000_0000, rd)
        apb(1'b0, gpio_port_pkg::OFF_DIR, 32'h0, 4'hf);
        `CHK("dir read", 32'h0000_00ff, rd)
        `CHK("oe", 8'h00, pin_oe)
        $display("test reset done");
        ext_level <= 8'h40;
        apb(1'b1, gpio_port_pkg::OFF_DIR, 32'h3f, 4'hf);
        apb(1'b1, gpio_port_pkg::OFF_DATA, 32'h80, 4'hf);
        `CHK("oe", 8'h3f, pin_oe)
        `CHK("out", 8'h80, pin_out)
        apb(1'b0, gpio_port_pkg::OFF_DATA, 32'h0, 4'hf);
        `CHK("mixed read", 32'h0000_0040, rd)
        $display("test mixed view done");
        apb(1'b1, gpio_port_pkg::OFF_CMD, 32'h08, 4'hf);
        repeat (3) @(posedge pclk);
        `CHK("out after set", 8'h41, pin_out)
        ext_level <= 8'h00;
        apb(1'b1, gpio_port_pkg::OFF_CMD, 32'h10, 4'hf);
        repeat (3) @(posedge pclk);
        `CHK("oe after clear", 8'hfe, pin_oe)
        ext_level <= 8'h40;
        apb(1'b0, gpio_port_pkg::OFF_DATA, 32'h0, 4'hf);
        `CHK("read after clear", 32'h0000_0040, rd)
        $display("test bit commands done");
        // Software repairs the direction byte from its own shadow copy.
        apb(1'b1, gpio_port_pkg::OFF_DIR, 32'h3e, 4'hf);
        `CHK("oe shadow", 8'h3e, pin_oe)
        apb(1'b1, gpio_port_pkg::OFF_DATA, 32'hc3, 4'h0);
        `CHK("out no strobe", 8'h41, pin_out)
        apb(1'b1, gpio_port_pkg::OFF_DATA, 32'hc3, 4'hf);
        `CHK("out all bits", 8'hc3, pin_out)
        apb(1'b0, gpio_port_pkg::OFF_DATA, 32'h0, 4'hf);
        `CHK("read mixed", 32'h0000_0042, rd)
        `CHK("no error", 1'b0, err)
        apb(1'b0, 12'h010, 32'h0, 4'hf);
        `CHK("unmapped error", 1'b1, err)
        apb(1'b1, 12'h010, 32'hff, 4'hf);
        `CHK("unmapped write err", 1'b1, err)
        `CHK("unmapped write out", 8'hc3, pin_out)
        `CHK("unmapped write oe", 8'h3e, pin_oe)
        apb(1'b0, gpio_port_pkg::OFF_STATUS, 32'h0, 4'hf);
        `CHK("status idle", 32'h0000_0000, rd)
        apb(1'b0, gpio_port_pkg::OFF_CMD, 32'h0, 4'hf);
        `CHK("cmd read", 32'h0000_0000, rd)
        $display("test full byte done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
